// ==== design/idma_consts.vh ====
`ifndef IDMA_CONSTS_VH
`define IDMA_CONSTS_VH

`define IDMA_NCTX        8
`define IDMA_FIFO_DEPTH  8
`define IDMA_FIFO_AW     3
`define IDMA_TX_WIDTH    33
`define IDMA_RX_WIDTH    32
`define IDMA_IDX_LAST    3'h7
`define IDMA_IDX_ONE     3'h1

// Arbiter owners
`define IDMA_OWN_NONE    2'h0
`define IDMA_OWN_TX      2'h1
`define IDMA_OWN_RX      2'h2

// Host addressing
`define IDMA_ADDR_STEP   32'h00000004
`define IDMA_LEN_ONE     16'h0001

// Descriptor word 0 and received header layout
`define IDMA_LEN_HI      31
`define IDMA_LEN_LO      16
`define IDMA_TAG_HI      15
`define IDMA_TAG_LO      14
`define IDMA_CHAN_HI     13
`define IDMA_CHAN_LO     8

// Marker entry: flag bit set, data zero
`define IDMA_MARK_WORD   33'h100000000

// Status read decode
`define IDMA_TGT_TXSTAT  2'h0
`define IDMA_TGT_RXSTAT  2'h1
`define IDMA_TGT_TXMASK  2'h2
`define IDMA_TGT_RXMASK  2'h3

`endif

// ==== design/idma_top.v ====
`timescale 1ns/1ns
`include "idma_consts.vh"

// Plain FIFO with a registered output slot and registered input ready
module idma_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk,
    input  wire             arst_n,
    input  wire             clkEn,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output reg              inReady,
    output reg  [WIDTH-1:0] outData,
    output reg              outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            doWr;
    wire            doRd;
    wire [AW:0]     next_count;

    assign doWr = inValid & inReady;
    assign doRd = (count != {(AW+1){1'b0}}) & (~outValid | outReady);
    assign next_count = count + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};

    // Storage array has no reset
    always @(posedge sys_clk) begin
        if (clkEn && doWr) begin
            mem[wrPtr] <= inData;
        end
    end

    // Ready is registered from the next count, so the source sees a flop and no slot is lost
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr    <= {AW{1'b0}};
            rdPtr    <= {AW{1'b0}};
            count    <= {(AW+1){1'b0}};
            inReady  <= 1'b1;
            outData  <= {WIDTH{1'b0}};
            outValid <= 1'b0;
        end else if (clkEn) begin
            count   <= next_count;
            inReady <= (next_count < DEPTH);
            if (doWr) begin
                wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doRd) begin
                outData  <= mem[rdPtr];
                outValid <= 1'b1;
                rdPtr    <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
            end else if (outReady) begin
                outValid <= 1'b0;
            end
        end
    end
endmodule // idma_fifo

// Isochronous transmit and receive engines with shared host port
module idma_top (
    input  wire         sys_clk,
    input  wire         arst_n,
    input  wire         clkEn,
    input  wire         cycleStart,
    input  wire [7:0]   txActive,
    input  wire [255:0] txDescAddr,
    input  wire [7:0]   rxActive,
    input  wire [47:0]  rxChan,
    input  wire [31:0]  rxTagEn,
    input  wire         rxMultiEn,
    input  wire [2:0]   rxMultiSel,
    input  wire [63:0]  rxMultiMask,
    input  wire [255:0] rxDescAddr,
    output reg          memReq,
    output reg          memWe,
    output reg  [31:0]  memAddr,
    output reg  [31:0]  memWdata,
    input  wire         memAck,
    input  wire [31:0]  memRdata,
    output wire [31:0]  linkTxData,
    output wire         linkTxMarker,
    output wire         linkTxValid,
    input  wire         linkTxReady,
    input  wire [31:0]  linkRxData,
    input  wire         linkRxValid,
    output wire         linkRxReady,
    input  wire [7:0]   txStatClr,
    input  wire [7:0]   rxStatClr,
    input  wire [7:0]   txIntMask,
    input  wire [7:0]   rxIntMask,
    input  wire         tgtRd,
    input  wire [1:0]   tgtAddr,
    output reg          tgtAck,
    output reg  [7:0]   tgtData,
    output reg  [7:0]   txStat,
    output reg  [7:0]   rxStat,
    output reg          isoIrq
);
    localparam T_IDLE = 3'h0;
    localparam T_CHK  = 3'h1;
    localparam T_REQ  = 3'h2;
    localparam T_D0   = 3'h3;
    localparam T_D1   = 3'h4;
    localparam T_DATA = 3'h5;
    localparam T_MARK = 3'h6;
    localparam T_NEXT = 3'h7;

    localparam R_IDLE = 3'h0;
    localparam R_HDR  = 3'h1;
    localparam R_REQ  = 3'h2;
    localparam R_DESC = 3'h3;
    localparam R_DATA = 3'h4;
    localparam R_DROP = 3'h5;

    reg  [2:0]  txSt;
    reg  [2:0]  txIdx;
    reg  [15:0] txLeft;
    reg  [31:0] txAddr;
    reg  [2:0]  rxSt;
    reg  [2:0]  rxIdx;
    reg  [15:0] rxLeft;
    reg  [31:0] rxAddr;
    reg  [31:0] rxHdr;
    reg         rxFirst;
    reg  [1:0]  owner;
    reg         busDone;
    reg  [31:0] busData;

    wire [32:0] txFifoIn;
    wire        txFifoInValid;
    wire        txFifoInReady;
    wire [32:0] txFifoOut;
    wire [31:0] rxFifoOut;
    wire        rxFifoOutValid;
    reg         rxFifoOutReady;

    reg         txCmdValid;
    reg         txCmdWe;
    reg  [31:0] txCmdAddr;
    reg         rxCmdValid;
    reg  [31:0] rxCmdAddr;
    reg  [31:0] rxCmdData;
    wire        txDone;
    wire        rxDone;
    wire        txRel;
    wire        rxRel;

    reg         hit;
    reg  [2:0]  hitIdx;
    wire [5:0]  hdrChan;
    wire [1:0]  hdrTag;
    integer     i;

    // Transmit FIFO toward the link; link drains it
    idma_fifo #(
        .WIDTH (`IDMA_TX_WIDTH),
        .DEPTH (`IDMA_FIFO_DEPTH),
        .AW    (`IDMA_FIFO_AW)
    ) txFifo (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .clkEn    (clkEn),
        .inData   (txFifoIn),
        .inValid  (txFifoInValid),
        .inReady  (txFifoInReady),
        .outData  (txFifoOut),
        .outValid (linkTxValid),
        .outReady (linkTxReady)
    );

    assign linkTxData   = txFifoOut[31:0];
    assign linkTxMarker = txFifoOut[32];

    // Receive FIFO filled by the link
    idma_fifo #(
        .WIDTH (`IDMA_RX_WIDTH),
        .DEPTH (`IDMA_FIFO_DEPTH),
        .AW    (`IDMA_FIFO_AW)
    ) rxFifo (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .clkEn    (clkEn),
        .inData   (linkRxData),
        .inValid  (linkRxValid),
        .inReady  (linkRxReady),
        .outData  (rxFifoOut),
        .outValid (rxFifoOutValid),
        .outReady (rxFifoOutReady)
    );

    assign txDone = busDone & (owner == `IDMA_OWN_TX);
    assign rxDone = busDone & (owner == `IDMA_OWN_RX);

    // Marker after a serviced context, payload words otherwise
    assign txFifoInValid = ((txSt == T_DATA) & txDone)
                         | ((txSt == T_MARK) & txFifoInReady);
    assign txFifoIn = (txSt == T_MARK) ? `IDMA_MARK_WORD
                                        : {1'b0, busData};
    assign txRel = (txSt == T_DATA) & (txLeft == 16'h0000);
    assign rxRel = ((txSt == T_IDLE) & 1'b0)
                 | ((rxSt == R_DATA) & (rxLeft == 16'h0000));

    // Transmit engine bus command
    always @* begin
        txCmdValid = 1'b0;
        txCmdWe    = 1'b0;
        txCmdAddr  = txAddr;
        case (txSt)
            T_D0: txCmdValid = 1'b1;
            T_D1: txCmdValid = 1'b1;
            // No fetch unless the FIFO can take the word
            T_DATA: txCmdValid = (txLeft != 16'h0000)
                               & txFifoInReady;
            default: txCmdValid = 1'b0;
        endcase
    end

    // Transmit sweep, one packet per active context per cycle
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            txSt   <= T_IDLE;
            txIdx  <= 3'h0;
            txLeft <= 16'h0000;
            txAddr <= 32'h00000000;
        end else if (clkEn) begin
            case (txSt)
                T_IDLE: begin
                    txIdx <= 3'h0;
                    if (cycleStart) begin
                        txSt <= T_CHK;
                    end
                end
                T_CHK: begin
                    if (txActive[txIdx]) begin
                        txAddr <= txDescAddr[txIdx*32 +: 32];
                        txSt   <= T_REQ;
                    end else begin
                        txSt <= T_NEXT;
                    end
                end
                T_REQ: begin
                    if (owner == `IDMA_OWN_TX) begin
                        txSt <= T_D0;
                    end
                end
                T_D0: begin
                    if (txDone) begin
                        txLeft <= busData[`IDMA_LEN_HI:`IDMA_LEN_LO];
                        txAddr <= txAddr + `IDMA_ADDR_STEP;
                        txSt   <= T_D1;
                    end
                end
                T_D1: begin
                    if (txDone) begin
                        txAddr <= busData;
                        txSt   <= T_DATA;
                    end
                end
                T_DATA: begin
                    if (txLeft == 16'h0000) begin
                        txSt <= T_MARK;
                    end else if (txDone) begin
                        txLeft <= txLeft - `IDMA_LEN_ONE;
                        txAddr <= txAddr + `IDMA_ADDR_STEP;
                    end
                end
                T_MARK: begin
                    if (txFifoInReady) begin
                        txSt <= T_NEXT;
                    end
                end
                default: begin
                    // Ascending visit; wait for the next cycle after 7
                    if (txIdx == `IDMA_IDX_LAST) begin
                        txSt <= T_IDLE;
                    end else begin
                        txIdx <= txIdx + `IDMA_IDX_ONE;
                        txSt  <= T_CHK;
                    end
                end
            endcase
        end
    end

    assign hdrChan = rxHdr[`IDMA_CHAN_HI:`IDMA_CHAN_LO];
    assign hdrTag  = rxHdr[`IDMA_TAG_HI:`IDMA_TAG_LO];

    // Header match against all contexts, lowest index wins
    always @* begin
        hit    = 1'b0;
        hitIdx = 3'h0;
        for (i = `IDMA_NCTX - 1; i >= 0; i = i - 1) begin
            if (rxActive[i] && rxTagEn[i*4 + hdrTag]) begin
                if (rxMultiEn && rxMultiSel == i[2:0]) begin
                    if (rxMultiMask[hdrChan]) begin
                        hit    = 1'b1;
                        hitIdx = i[2:0];
                    end
                end else if (rxChan[i*6 +: 6] == hdrChan) begin
                    hit    = 1'b1;
                    hitIdx = i[2:0];
                end
            end
        end
    end

    // Receive command and FIFO pops
    always @* begin
        rxCmdValid     = 1'b0;
        rxCmdAddr      = rxAddr;
        rxCmdData      = rxFirst ? rxHdr : rxFifoOut;
        rxFifoOutReady = 1'b0;
        case (rxSt)
            R_IDLE: rxFifoOutReady = 1'b1;
            R_DESC: rxCmdValid = 1'b1;
            R_DATA: begin
                rxCmdValid = (rxLeft != 16'h0000)
                           & (rxFirst | rxFifoOutValid);
                rxFifoOutReady = rxDone & ~rxFirst;
            end
            R_DROP: rxFifoOutReady = (rxLeft != 16'h0000);
            default: rxFifoOutReady = 1'b0;
        endcase
    end

    // Receive engine
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxSt    <= R_IDLE;
            rxIdx   <= 3'h0;
            rxLeft  <= 16'h0000;
            rxAddr  <= 32'h00000000;
            rxHdr   <= 32'h00000000;
            rxFirst <= 1'b0;
        end else if (clkEn) begin
            case (rxSt)
                R_IDLE: begin
                    if (rxFifoOutValid) begin
                        rxHdr <= rxFifoOut;
                        rxSt  <= R_HDR;
                    end
                end
                R_HDR: begin
                    rxIdx <= hitIdx;
                    if (hit) begin
                        rxAddr <= rxDescAddr[hitIdx*32 +: 32];
                        rxLeft <= rxHdr[`IDMA_LEN_HI:`IDMA_LEN_LO]
                                + `IDMA_LEN_ONE;
                        rxSt   <= R_REQ;
                    end else begin
                        rxLeft <= rxHdr[`IDMA_LEN_HI:`IDMA_LEN_LO];
                        rxSt   <= R_DROP;
                    end
                end
                R_REQ: begin
                    if (owner == `IDMA_OWN_RX) begin
                        rxSt <= R_DESC;
                    end
                end
                R_DESC: begin
                    if (rxDone) begin
                        rxAddr  <= busData;
                        rxFirst <= 1'b1;
                        rxSt    <= R_DATA;
                    end
                end
                R_DATA: begin
                    if (rxLeft == 16'h0000) begin
                        rxSt <= R_IDLE;
                    end else if (rxDone) begin
                        rxFirst <= 1'b0;
                        rxLeft  <= rxLeft - `IDMA_LEN_ONE;
                        rxAddr  <= rxAddr + `IDMA_ADDR_STEP;
                    end
                end
                default: begin
                    if (rxLeft == 16'h0000) begin
                        rxSt <= R_IDLE;
                    end else if (rxFifoOutValid) begin
                        rxLeft <= rxLeft - `IDMA_LEN_ONE;
                    end
                end
            endcase
        end
    end

    // Arbiter and host port; owner holds the bus for a whole packet
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            owner    <= `IDMA_OWN_NONE;
            memReq   <= 1'b0;
            memWe    <= 1'b0;
            memAddr  <= 32'h00000000;
            memWdata <= 32'h00000000;
            busDone  <= 1'b0;
            busData  <= 32'h00000000;
        end else if (clkEn) begin
            busDone <= 1'b0;
            if (owner == `IDMA_OWN_NONE) begin
                if (txSt == T_REQ) begin
                    owner <= `IDMA_OWN_TX;
                end else if (rxSt == R_REQ) begin
                    owner <= `IDMA_OWN_RX;
                end
            end else if ((owner == `IDMA_OWN_TX && txRel)
                      || (owner == `IDMA_OWN_RX && rxRel)) begin
                owner <= `IDMA_OWN_NONE;
            end
            if (memReq) begin
                if (memAck) begin
                    memReq  <= 1'b0;
                    busDone <= 1'b1;
                    busData <= memRdata;
                end
            end else if (!busDone) begin
                // One cycle gap after each answer lets the engine move on
                if (owner == `IDMA_OWN_TX && txCmdValid) begin
                    memReq  <= 1'b1;
                    memWe   <= txCmdWe;
                    memAddr <= txCmdAddr;
                end else if (owner == `IDMA_OWN_RX && rxCmdValid) begin
                    memReq   <= 1'b1;
                    memWe    <= (rxSt == R_DATA);
                    memAddr  <= rxCmdAddr;
                    memWdata <= rxCmdData;
                end
            end
        end
    end

    // Sticky status, set beats clear, masked onto the interrupt
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            txStat  <= 8'h00;
            rxStat  <= 8'h00;
            isoIrq  <= 1'b0;
            tgtAck  <= 1'b0;
            tgtData <= 8'h00;
        end else if (clkEn) begin
            txStat <= (txStat & ~txStatClr)
                    | ({7'h00, txRel & ~txDone} << txIdx);
            rxStat <= (rxStat & ~rxStatClr)
                    | ({7'h00, rxRel} << rxIdx);
            isoIrq <= |(txStat & txIntMask)
                    | |(rxStat & rxIntMask);
            tgtAck <= tgtRd;
            if (!tgtRd) begin
                tgtData <= 8'h00;
            end else if (tgtAddr == `IDMA_TGT_TXSTAT) begin
                tgtData <= txStat;
            end else if (tgtAddr == `IDMA_TGT_RXSTAT) begin
                tgtData <= rxStat;
            end else if (tgtAddr == `IDMA_TGT_TXMASK) begin
                tgtData <= txIntMask;
            end else begin
                tgtData <= rxIntMask;
            end
        end
    end
endmodule // idma_top

// ==== sim/idma_far_model.sv ====
`timescale 1ns/1ns
// Host memory and link-side sink facing the engines
module idma_far_model (
    input  logic        sys_clk,
    input  logic        arst_n,
    input  logic [3:0]  lat,
    input  logic        stall,
    input  logic        memReq,
    input  logic        memWe,
    input  logic [31:0] memAddr,
    input  logic [31:0] memWdata,
    output logic        memAck,
    output logic [31:0] memRdata,
    input  logic [31:0] linkTxData,
    input  logic        linkTxMarker,
    input  logic        linkTxValid,
    output logic        linkTxReady
);
    logic [31:0] mem [0:255];
    logic [32:0] txLog [0:31];
    logic [3:0]  waitCnt;
    logic        done;
    integer      accCnt;
    integer      txCnt;
    // Link drains the FIFO unless told to stall
    assign linkTxReady = !stall;
    // One answer per access after lat wait cycles
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            memAck <= 1'b0;
            memRdata <= 32'h00000000;
            waitCnt <= 4'h0;
            done <= 1'b0;
            accCnt <= 0;
        end else begin
            memAck <= 1'b0;
            // Idle read bus toggles so stale data never looks valid
            memRdata <= ~memRdata;
            if (!memReq) begin
                waitCnt <= 4'h0;
                done <= 1'b0;
            end else if (!done && waitCnt >= lat) begin
                memAck <= 1'b1;
                done <= 1'b1;
                accCnt <= accCnt + 1;
                if (memWe)
                    mem[memAddr[9:2]] <= memWdata;
                else
                    memRdata <= mem[memAddr[9:2]];
            end else if (!done) begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
    // Log every entry the link takes
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            txCnt <= 0;
        else if (linkTxValid && linkTxReady) begin
            txLog[txCnt[4:0]] <= {linkTxMarker, linkTxData};
            txCnt <= txCnt + 1;
        end
    end
endmodule // idma_far_model

// ==== sim/idma_top_sva.sv ====
`timescale 1ns/1ns
// Port-level protocol watcher for the engines
module idma_top_sva (
    input logic        sys_clk,
    input logic        arst_n,
    input logic        clkEn,
    input logic        memReq,
    input logic        memWe,
    input logic [31:0] memAddr,
    input logic [31:0] memWdata,
    input logic        memAck,
    input logic [31:0] linkTxData,
    input logic        linkTxMarker,
    input logic        linkTxValid,
    input logic        linkTxReady,
    input logic        tgtRd,
    input logic [1:0]  tgtAddr,
    input logic        tgtAck,
    input logic [7:0]  tgtData,
    input logic [7:0]  txStat,
    input logic [7:0]  rxStat,
    input logic [7:0]  txStatClr,
    input logic [7:0]  rxStatClr,
    input logic [7:0]  txIntMask,
    input logic [7:0]  rxIntMask,
    input logic        isoIrq
);
    logic [31:0] allV;
    logic [7:0]  selV;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Expected read byte, picked on the same edge as the answer
    assign allV = {rxIntMask, txIntMask, rxStat, txStat};
    always @(posedge sys_clk) begin
        selV <= allV[tgtAddr*8 +: 8];
    end
    sequence s_acc_done;
        clkEn && memReq && memAck;
    endsequence
    sequence s_gap;
        !memReq ##1 !memReq;
    endsequence
    a_req_hold: assert property (memReq && !memAck |=> memReq
        && $stable({memWe, memAddr, memWdata}))
        else $error("host request changed before its answer");
    a_req_gap: assert property (s_acc_done |=> s_gap)
        else $error("host request not released with idle gap");
    a_tgt_answer: assert property (clkEn && tgtRd |=> tgtAck)
        else $error("status read not answered next cycle");
    a_tgt_data: assert property (clkEn && tgtRd |=> tgtData == selV)
        else $error("status read returned wrong source");
    a_irq_follow: assert property ($past(clkEn) |-> isoIrq ==
        $past(((txStat & txIntMask) | (rxStat & rxIntMask)) != 8'h00))
        else $error("interrupt does not follow masked status");
    a_mark_zero: assert property (linkTxValid && linkTxMarker
        |-> linkTxData == 32'h00000000)
        else $error("marker entry carries data");
    a_txout_hold: assert property (clkEn && linkTxValid
        && !linkTxReady |=> linkTxValid
        && $stable({linkTxMarker, linkTxData}))
        else $error("transmit word dropped while stalled");
    a_txstat_stick: assert property (clkEn |=>
        ($past(txStat & ~txStatClr) & ~txStat) == 8'h00)
        else $error("transmit status fell without clear");
    a_rxstat_stick: assert property (clkEn |=>
        ($past(rxStat & ~rxStatClr) & ~rxStat) == 8'h00)
        else $error("receive status fell without clear");
endmodule // idma_top_sva

bind idma_top idma_top_sva i_sva (.sys_clk, .arst_n, .clkEn, .memReq,
    .memWe, .memAddr, .memWdata, .memAck, .linkTxData, .linkTxMarker,
    .linkTxValid, .linkTxReady, .tgtRd, .tgtAddr, .tgtAck, .tgtData,
    .txStat, .rxStat, .txStatClr, .rxStatClr, .txIntMask, .rxIntMask,
    .isoIrq);

// ==== sim/idma_top_tb.sv ====
`timescale 1ns/1ns
// Self-checking bench for the isochronous engines
module idma_top_tb;
    logic         sys_clk, arst_n, clkEn, cycleStart, rxMultiEn, stall;
    logic         memReq, memWe, memAck, linkTxMarker, linkTxValid;
    logic         linkTxReady, linkRxValid, linkRxReady, tgtRd, tgtAck;
    logic         isoIrq;
    logic [1:0]   tgtAddr;
    logic [2:0]   rxMultiSel;
    logic [3:0]   lat;
    logic [7:0]   txActive, rxActive, txStatClr, rxStatClr, txIntMask;
    logic [7:0]   rxIntMask, tgtData, txStat, rxStat;
    logic [31:0]  memAddr, memWdata, memRdata, linkTxData, linkRxData;
    logic [31:0]  rxTagEn;
    logic [47:0]  rxChan;
    logic [63:0]  rxMultiMask;
    logic [255:0] txDescAddr, rxDescAddr;
    integer       miscompares, checked, n, k, base;

    idma_top i_dut (.sys_clk, .arst_n, .clkEn, .cycleStart, .txActive,
        .txDescAddr, .rxActive, .rxChan, .rxTagEn, .rxMultiEn, .rxMultiSel,
        .rxMultiMask, .rxDescAddr, .memReq, .memWe, .memAddr, .memWdata,
        .memAck, .memRdata, .linkTxData, .linkTxMarker, .linkTxValid,
        .linkTxReady, .linkRxData, .linkRxValid, .linkRxReady, .txStatClr,
        .rxStatClr, .txIntMask, .rxIntMask, .tgtRd, .tgtAddr, .tgtAck,
        .tgtData, .txStat, .rxStat, .isoIrq);
    idma_far_model i_mem (.sys_clk, .arst_n, .lat, .stall, .memReq, .memWe,
        .memAddr, .memWdata, .memAck, .memRdata, .linkTxData, .linkTxMarker,
        .linkTxValid, .linkTxReady);

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    task chk(input string what, input logic [32:0] e, input logic [32:0] g);
        checked = checked + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Header then payload, valid held up across words
    task rx_pkt(input logic [31:0] hdr, input logic [31:0] pay);
        @(posedge sys_clk);
        for (k = 0; k <= hdr[31:16]; k++) begin
            linkRxData <= (k == 0) ? hdr : pay + k;
            linkRxValid <= 1'b1;
            @(posedge sys_clk);
            for (n = 0; n < 500 && linkRxReady !== 1'b1; n++)
                @(posedge sys_clk);
        end
        linkRxValid <= 1'b0;
        linkRxData <= 32'hffffffff;
    endtask

    // Skipped context, zero-length packet, last index, stalled link
    task t_tx;
        for (n = 0; n < 10; n++) i_mem.mem[64+n] = 32'ha0000000 + n;
        i_mem.mem[16] = 32'h000a0000;
        i_mem.mem[17] = 32'h00000100;
        i_mem.mem[18] = 32'h00000000;
        i_mem.mem[19] = 32'h00000140;
        i_mem.mem[20] = 32'h00010000;
        i_mem.mem[21] = 32'h00000180;
        i_mem.mem[96] = 32'hb0000000;
        @(posedge sys_clk);
        lat <= 4'h3;
        stall <= 1'b1;
        txActive <= 8'h85;
        txDescAddr[31:0] <= 32'h00000040;
        txDescAddr[95:64] <= 32'h00000048;
        txDescAddr[255:224] <= 32'h00000050;
        cycleStart <= 1'b1;
        @(posedge sys_clk);
        cycleStart <= 1'b0;
        repeat (150) @(posedge sys_clk);
        chk("fetch stalled", 1'b1, i_mem.accCnt < 12);
        stall <= 1'b0;
        for (n = 0; n < 3000 && (i_mem.txCnt < 14 || memReq); n++)
            @(posedge sys_clk);
        for (n = 0; n < 14; n++)
            chk("tx entry", n < 10 ? {1'b0, 32'ha0000000 + n} :
                n == 12 ? 33'h0b0000000 : 33'h100000000, i_mem.txLog[n]);
        chk("tx accesses", 17, i_mem.accCnt);
        chk("tx status", 8'h85, txStat);
    endtask

    // Two contexts share a channel, the lower index owns it
    task t_rx_match;
        i_mem.mem[24] = 32'h00000200;
        @(posedge sys_clk);
        lat <= 4'h0;
        rxActive <= 8'h4a;
        rxChan[23:18] <= 6'h05;
        rxChan[41:36] <= 6'h05;
        rxTagEn[13] <= 1'b1;
        rxTagEn[27:24] <= 4'hf;
        rxDescAddr[127:96] <= 32'h00000060;
        rx_pkt(32'h00024500, 32'hc0000000);
        for (n = 0; n < 2000 && (rxStat[3] !== 1'b1 || memReq); n++)
            @(posedge sys_clk);
        chk("rx header", 32'h00024500, i_mem.mem[128]);
        chk("rx word 1", 32'hc0000001, i_mem.mem[129]);
        chk("rx word 2", 32'hc0000002, i_mem.mem[130]);
        chk("rx status", 8'h08, rxStat);
    endtask

    // Unmatched packet drained silently, then a multichannel one lands
    task t_rx_multi;
        i_mem.mem[26] = 32'h00000280;
        @(posedge sys_clk);
        rxMultiEn <= 1'b1;
        rxMultiSel <= 3'h1;
        rxMultiMask[9] <= 1'b1;
        rxTagEn[4] <= 1'b1;
        rxDescAddr[63:32] <= 32'h00000068;
        base = i_mem.accCnt;
        rx_pkt(32'h00031400, 32'hd0000000);
        rx_pkt(32'h00010900, 32'he0000000);
        for (n = 0; n < 2000 && (rxStat[1] !== 1'b1 || memReq); n++)
            @(posedge sys_clk);
        chk("rx accesses", base + 3, i_mem.accCnt);
        chk("multi header", 32'h00010900, i_mem.mem[160]);
        chk("multi word", 32'he0000001, i_mem.mem[161]);
    endtask

    // Status reads, masking into the interrupt, clearing
    task t_status;
        @(posedge sys_clk);
        txIntMask <= 8'h04;
        rxIntMask <= 8'h08;
        for (k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            tgtRd <= 1'b1;
            tgtAddr <= k[1:0];
            @(posedge sys_clk);
            tgtRd <= 1'b0;
            #1;
            chk("tgt ack", 1'b1, tgtAck);
            chk("tgt data", (32'h08040a85 >> 8*k) & 8'hff, tgtData);
        end
        chk("irq raised", 1'b1, isoIrq);
        @(posedge sys_clk);
        txStatClr <= 8'h04;
        rxStatClr <= 8'h0a;
        @(posedge sys_clk);
        txStatClr <= 8'h00;
        rxStatClr <= 8'h00;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("tx cleared", 8'h81, txStat);
        chk("rx cleared", 8'h00, rxStat);
        chk("irq cleared", 1'b0, isoIrq);
    endtask

    // Reset, then the scenarios in order
    initial begin
        miscompares = 0;
        checked = 0;
        arst_n = 1'b0;
        clkEn = 1'b1;
        {cycleStart, stall, rxMultiEn, linkRxValid, tgtRd} = 5'h00;
        {lat, rxMultiSel, tgtAddr} = 9'h000;
        {txActive, rxActive, txStatClr, rxStatClr} = 32'h00000000;
        {txIntMask, rxIntMask} = 16'h0000;
        {rxTagEn, linkRxData, rxChan, rxMultiMask} = 176'h0;
        {txDescAddr, rxDescAddr} = 512'h0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_tx;
        t_rx_match;
        t_rx_multi;
        t_status;
        give_verdict;
    end

    // Whole run needs a few hundred cycles; ten thousand is a hang
    initial begin
        #100000;
        miscompares = miscompares + 1;
        give_verdict;
    end
endmodule // idma_top_tb
